//--- shared/rxpi_pkg.sv
// constants and state types for the receive port interrupt status block
package rxpi_pkg;
   localparam int NUM_PORTS = 4;
   localparam int NUM_LINES = 4;
   localparam int PORT_W    = 2;
   localparam int LINE_BITS = NUM_PORTS * NUM_LINES;

   // register byte addresses
   localparam logic [7:0] ADDR_PORT_SEL = 8'h4c;
   localparam logic [7:0] ADDR_IE_HI    = 8'hd8;
   localparam logic [7:0] ADDR_IE_LO    = 8'hd9;
   localparam logic [7:0] ADDR_ISR_HI   = 8'hda;
   localparam logic [7:0] ADDR_ISR_LO   = 8'hdb;
   localparam logic [7:0] ADDR_LINE_STS = 8'hdc;
   localparam logic [7:0] ADDR_EDGE_IE  = 8'hdd;

   // upper status bit positions
   localparam int HI_ENC_BIT = 2;
   localparam int HI_SEQ_BIT = 1;
   localparam int HI_CRC_BIT = 0;
   // lower status bit positions
   localparam int LO_LEN_BIT = 6;
   localparam int LO_CNT_BIT = 5;
   localparam int LO_OVF_BIT = 4;
   localparam int LO_PAR_BIT = 2;
   localparam int LO_VAL_BIT = 1;
   localparam int LO_LCK_BIT = 0;
   // line status layout: irq flags high nibble, live levels low nibble
   localparam int LINE_IRQ_LSB = 4;
   localparam int LINE_VAL_LSB = 0;

   // implemented bits of each register
   localparam logic [7:0] MASK_HI   = 8'h07;
   localparam logic [7:0] MASK_LO   = 8'h77;
   localparam logic [7:0] MASK_SEL  = 8'h03;
   localparam logic [7:0] RESET_REG = 8'h00;

   typedef struct packed {
      logic [PORT_W-1:0]           port_sel;
      logic [NUM_PORTS-1:0][7:0]   err_hi;
      logic [NUM_PORTS-1:0][7:0]   evt_lo;
      logic [NUM_PORTS-1:0][3:0]   line_irq;
      logic [NUM_PORTS-1:0][7:0]   ie_hi;
      logic [NUM_PORTS-1:0][7:0]   ie_lo;
      logic [NUM_PORTS-1:0][7:0]   edge_ie;
      logic [7:0]                  rdata;
      logic                        rvalid;
   } rxpi_state_t;
endpackage

//--- rtl/rxpi_edge.sv
// rise and fall detector for a vector of levels
`timescale 1ns/1ns
module rxpi_edge #(
   parameter int W = 1
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_resetn,
   input  wire logic [W-1:0] i_level,
   output logic      [W-1:0] o_rise,
   output logic      [W-1:0] o_fall
);
   typedef struct packed {
      logic [W-1:0] prev;
      logic         primed;
   } rxpi_edge_state_t;

   rxpi_edge_state_t s;
   rxpi_edge_state_t next_s;

   // no edge until the first sample is held, so reset is no change
   assign o_rise = s.primed ? (i_level & ~s.prev) : '0;
   assign o_fall = s.primed ? (~i_level & s.prev) : '0;

   // track the last level each cycle
   always_comb begin
      next_s        = s;
      next_s.prev   = i_level;
      next_s.primed = 1'b1;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

//--- rtl/rxpi_top.sv
// per receive port interrupt status, enables and forward line status
`timescale 1ns/1ns
module rxpi_top (
   input  wire logic                             i_sys_clk,
   input  wire logic                             i_resetn,
   input  wire logic [7:0]                       i_reg_addr,
   input  wire logic                             i_reg_rd,
   input  wire logic                             i_reg_wr,
   input  wire logic [7:0]                       i_reg_wdata,
   output logic      [7:0]                       o_reg_rdata,
   output logic                                  o_reg_rvalid,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_encode_error,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_ctrl_seq_error,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_ctrl_crc_error,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_line_length_changed,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_line_count_changed,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_rx_overflow,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_link_parity_error,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_port_valid,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_link_lock,
   input  wire logic [rxpi_pkg::LINE_BITS-1:0]   i_fwd_line,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_status_first_rd,
   input  wire logic [rxpi_pkg::NUM_PORTS-1:0]   i_status_second_rd,
   output logic      [rxpi_pkg::NUM_PORTS-1:0]   o_port_irq,
   output logic      [rxpi_pkg::NUM_PORTS-1:0]   o_line_irq
);
   import rxpi_pkg::*;

   rxpi_state_t                   s;
   rxpi_state_t                   next_s;
   logic [NUM_PORTS-1:0][7:0]     set_hi;
   logic [NUM_PORTS-1:0][7:0]     clr_hi;
   logic [NUM_PORTS-1:0][7:0]     set_lo;
   logic [NUM_PORTS-1:0][7:0]     clr_lo;
   logic [NUM_PORTS-1:0][3:0]     set_line;
   logic [NUM_PORTS-1:0][3:0]     clr_line;
   logic [NUM_PORTS-1:0]          valid_rise;
   logic [NUM_PORTS-1:0]          valid_fall;
   logic [NUM_PORTS-1:0]          lock_rise;
   logic [NUM_PORTS-1:0]          lock_fall;
   logic [LINE_BITS-1:0]          line_rise;
   logic [LINE_BITS-1:0]          line_fall;
   logic [7:0]                    rd_mux;
   logic [3:0]                    live_sel;

   // change detection on port-valid and lock levels
   rxpi_edge #(.W(NUM_PORTS)) u_valid_edge (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_level   (i_port_valid),
      .o_rise    (valid_rise),
      .o_fall    (valid_fall)
   );

   rxpi_edge #(.W(NUM_PORTS)) u_lock_edge (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_level   (i_link_lock),
      .o_rise    (lock_rise),
      .o_fall    (lock_fall)
   );

   // edges of every forward line of every port
   rxpi_edge #(.W(LINE_BITS)) u_line_edge (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_level   (i_fwd_line),
      .o_rise    (line_rise),
      .o_fall    (line_fall)
   );

   // set and clear terms; reads of the isr registers never appear here
   genvar p;
   genvar k;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         always_comb begin
            set_hi[p]             = '0;
            clr_hi[p]             = '0;
            set_lo[p]             = '0;
            clr_lo[p]             = '0;
            set_hi[p][HI_ENC_BIT] = i_encode_error[p];
            clr_hi[p][HI_ENC_BIT] = i_status_second_rd[p];
            set_hi[p][HI_SEQ_BIT] = i_ctrl_seq_error[p];
            clr_hi[p][HI_SEQ_BIT] = i_status_first_rd[p];
            set_hi[p][HI_CRC_BIT] = i_ctrl_crc_error[p];
            clr_hi[p][HI_CRC_BIT] = i_status_first_rd[p];
            set_lo[p][LO_LEN_BIT] = i_line_length_changed[p];
            clr_lo[p][LO_LEN_BIT] = i_status_second_rd[p];
            set_lo[p][LO_CNT_BIT] = i_line_count_changed[p];
            clr_lo[p][LO_CNT_BIT] = i_status_second_rd[p];
            set_lo[p][LO_OVF_BIT] = i_rx_overflow[p];
            clr_lo[p][LO_OVF_BIT] = i_status_second_rd[p];
            set_lo[p][LO_PAR_BIT] = i_link_parity_error[p];
            clr_lo[p][LO_PAR_BIT] = i_status_first_rd[p];
            set_lo[p][LO_VAL_BIT] = valid_rise[p] | valid_fall[p];
            clr_lo[p][LO_VAL_BIT] = i_status_first_rd[p];
            set_lo[p][LO_LCK_BIT] = lock_rise[p] | lock_fall[p];
            clr_lo[p][LO_LCK_BIT] = i_status_first_rd[p];
         end

         // line condition: enabled rise or enabled fall
         for (k = 0; k < NUM_LINES; k++) begin : g_line
            assign set_line[p][k] =
               (line_rise[p*NUM_LINES+k] & s.edge_ie[p][2*k]) |
               (line_fall[p*NUM_LINES+k] & s.edge_ie[p][2*k+1]);
         end
         // read of the line status register of this port clears it
         assign clr_line[p] = {4{i_reg_rd && i_reg_addr == ADDR_LINE_STS
                                && s.port_sel == PORT_W'(p)}};

         // enable gating onto the port interrupt
         assign o_port_irq[p] = |(s.err_hi[p] & s.ie_hi[p]) |
                                |(s.evt_lo[p] & s.ie_lo[p]);
         assign o_line_irq[p] = |s.line_irq[p];
      end
   endgenerate

   // live levels of the selected port, sampled at the read itself
   assign live_sel = i_fwd_line[s.port_sel*NUM_LINES +: NUM_LINES];

   // read mux over the selected port copy
   always_comb begin
      unique case (i_reg_addr)
         ADDR_PORT_SEL: rd_mux = {6'h00, s.port_sel};
         ADDR_IE_HI:    rd_mux = s.ie_hi[s.port_sel];
         ADDR_IE_LO:    rd_mux = s.ie_lo[s.port_sel];
         ADDR_ISR_HI:   rd_mux = s.err_hi[s.port_sel];
         ADDR_ISR_LO:   rd_mux = s.evt_lo[s.port_sel];
         ADDR_LINE_STS: rd_mux = {s.line_irq[s.port_sel], live_sel};
         default:       rd_mux = RESET_REG; // unmapped and write-only
      endcase
   end

   // next state: set beats clear, writes go to the selected copy
   always_comb begin
      next_s        = s;
      next_s.rvalid = i_reg_rd;
      if (i_reg_rd) begin
         next_s.rdata = rd_mux;
      end
      for (int i = 0; i < NUM_PORTS; i++) begin
         next_s.err_hi[i]   = ((s.err_hi[i] & ~clr_hi[i]) | set_hi[i])
                              & MASK_HI;
         next_s.evt_lo[i]   = ((s.evt_lo[i] & ~clr_lo[i]) | set_lo[i])
                              & MASK_LO;
         next_s.line_irq[i] = (s.line_irq[i] & ~clr_line[i])
                              | set_line[i];
      end
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            ADDR_PORT_SEL: next_s.port_sel = i_reg_wdata[PORT_W-1:0];
            ADDR_IE_HI:    next_s.ie_hi[s.port_sel] = i_reg_wdata & MASK_HI;
            ADDR_IE_LO:    next_s.ie_lo[s.port_sel] = i_reg_wdata & MASK_LO;
            ADDR_EDGE_IE:  next_s.edge_ie[s.port_sel] = i_reg_wdata;
            default:       next_s.rvalid = next_s.rvalid; // read-only
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_reg_rdata  = s.rdata;
   assign o_reg_rvalid = s.rvalid;

   // checks on port 0 and the register port
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_line_read0;
      i_reg_rd && i_reg_addr == ADDR_LINE_STS && s.port_sel == 2'h0;
   endsequence
   sequence s_isr_read0;
      i_reg_rd && (i_reg_addr == ADDR_ISR_HI || i_reg_addr == ADDR_ISR_LO)
      && !i_status_first_rd[0] && !i_status_second_rd[0];
   endsequence

   property p_enc_set;
      i_encode_error[0] |=> s.err_hi[0][HI_ENC_BIT] [*2] or
      (s.err_hi[0][HI_ENC_BIT] ##1 $past(i_status_second_rd[0]));
   endproperty
   a_enc_set: assert property (p_enc_set) else $error("enc bit lost");

   property p_seq_set;
      i_ctrl_seq_error[0] |=> s.err_hi[0][HI_SEQ_BIT];
   endproperty
   a_seq_set: assert property (p_seq_set) else $error("seq bit");

   property p_crc_hold;
      s.err_hi[0][HI_CRC_BIT] && !i_status_first_rd[0]
      |=> s.err_hi[0][HI_CRC_BIT];
   endproperty
   a_crc_hold: assert property (p_crc_hold) else $error("crc lost");

   property p_len_clear;
      i_status_second_rd[0] && !i_line_length_changed[0]
      |=> !s.evt_lo[0][LO_LEN_BIT];
   endproperty
   a_len_clear: assert property (p_len_clear) else $error("len");

   property p_cnt_set;
      i_line_count_changed[0] |=> s.evt_lo[0][LO_CNT_BIT];
   endproperty
   a_cnt_set: assert property (p_cnt_set) else $error("cnt bit");

   property p_ovf_keep;
      s.evt_lo[0][LO_OVF_BIT] && i_status_first_rd[0]
      && !i_status_second_rd[0] |=> s.evt_lo[0][LO_OVF_BIT];
   endproperty
   a_ovf_keep: assert property (p_ovf_keep) else $error("ovf");

   property p_par_clear;
      i_status_first_rd[0] && !i_link_parity_error[0]
      |=> !s.evt_lo[0][LO_PAR_BIT];
   endproperty
   a_par_clear: assert property (p_par_clear) else $error("par");

   property p_valid_chg;
      $changed(i_port_valid[0]) && $past(i_resetn, 2)
      |-> ##1 s.evt_lo[0][LO_VAL_BIT];
   endproperty
   a_valid_chg: assert property (p_valid_chg) else $error("valid");

   property p_lock_chg;
      $changed(i_link_lock[0]) && $past(i_resetn, 2)
      |-> ##1 s.evt_lo[0][LO_LCK_BIT];
   endproperty
   a_lock_chg: assert property (p_lock_chg) else $error("lock");

   property p_line_clear;
      s_line_read0 ##0 !(|set_line[0]) |=> s.line_irq[0] == 4'h0;
   endproperty
   a_line_clear: assert property (p_line_clear) else $error("line");

   property p_live_read;
      s_line_read0 |=> o_reg_rvalid
      && o_reg_rdata[3:0] == $past(i_fwd_line[3:0]);
   endproperty
   a_live_read: assert property (p_live_read) else $error("live");

   property p_copy_apart;
      i_reg_wr && i_reg_addr == ADDR_IE_LO && s.port_sel != 2'h0
      |=> $stable(s.ie_lo[0]);
   endproperty
   a_copy_apart: assert property (p_copy_apart) else $error("copy");

   property p_irq_gate;
      s.ie_hi[0] == 8'h00 && s.ie_lo[0] == 8'h00 |-> !o_port_irq[0];
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq");

   property p_rise_set;
      line_rise[0] && s.edge_ie[0][0] |=> s.line_irq[0][0];
   endproperty
   a_rise_set: assert property (p_rise_set) else $error("rise");

   property p_isr_read;
      s_isr_read0 |=> (s.err_hi[0] & $past(s.err_hi[0]))
      == $past(s.err_hi[0]);
   endproperty
   a_isr_read: assert property (p_isr_read) else $error("isr");
endmodule

//--- dv/rxpi_top_test.sv
// self-checking register-level testbench for the receive port status block
`timescale 1ns/1ns
module rxpi_top_test;
   import rxpi_pkg::*;

   logic                 i_sys_clk;
   logic                 i_resetn;
   logic [7:0]           i_reg_addr;
   logic                 i_reg_rd;
   logic                 i_reg_wr;
   logic [7:0]           i_reg_wdata;
   logic [7:0]           o_reg_rdata;
   logic                 o_reg_rvalid;
   logic [NUM_PORTS-1:0] i_encode_error;
   logic [NUM_PORTS-1:0] i_ctrl_seq_error;
   logic [NUM_PORTS-1:0] i_ctrl_crc_error;
   logic [NUM_PORTS-1:0] i_line_length_changed;
   logic [NUM_PORTS-1:0] i_line_count_changed;
   logic [NUM_PORTS-1:0] i_rx_overflow;
   logic [NUM_PORTS-1:0] i_link_parity_error;
   logic [NUM_PORTS-1:0] i_port_valid;
   logic [NUM_PORTS-1:0] i_link_lock;
   logic [LINE_BITS-1:0] i_fwd_line;
   logic [NUM_PORTS-1:0] i_status_first_rd;
   logic [NUM_PORTS-1:0] i_status_second_rd;
   logic [NUM_PORTS-1:0] o_port_irq;
   logic [NUM_PORTS-1:0] o_line_irq;
   int                   err_count;
   int                   compares;
   int                   cycles;

   // event table: status register, bit, cleared by second status read
   logic [7:0] ev_addr [0:8] = '{ADDR_ISR_HI, ADDR_ISR_HI, ADDR_ISR_HI,
      ADDR_ISR_LO, ADDR_ISR_LO, ADDR_ISR_LO, ADDR_ISR_LO, ADDR_ISR_LO,
      ADDR_ISR_LO};
   logic [7:0] ev_mask [0:8] = '{8'h04, 8'h02, 8'h01, 8'h40, 8'h20, 8'h10,
      8'h04, 8'h02, 8'h01};
   logic       ev_sec  [0:8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0,
      1'b0, 1'b0};

   rxpi_top dut (
      .i_sys_clk            (i_sys_clk),
      .i_resetn             (i_resetn),
      .i_reg_addr           (i_reg_addr),
      .i_reg_rd             (i_reg_rd),
      .i_reg_wr             (i_reg_wr),
      .i_reg_wdata          (i_reg_wdata),
      .o_reg_rdata          (o_reg_rdata),
      .o_reg_rvalid         (o_reg_rvalid),
      .i_encode_error       (i_encode_error),
      .i_ctrl_seq_error     (i_ctrl_seq_error),
      .i_ctrl_crc_error     (i_ctrl_crc_error),
      .i_line_length_changed(i_line_length_changed),
      .i_line_count_changed (i_line_count_changed),
      .i_rx_overflow        (i_rx_overflow),
      .i_link_parity_error  (i_link_parity_error),
      .i_port_valid         (i_port_valid),
      .i_link_lock          (i_link_lock),
      .i_fwd_line           (i_fwd_line),
      .i_status_first_rd    (i_status_first_rd),
      .i_status_second_rd   (i_status_second_rd),
      .o_port_irq           (o_port_irq),
      .o_line_irq           (o_line_irq)
   );

   // 100 MHz clock
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      if (err_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // hang guard, generous for about six hundred cycles of traffic
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         summarize();
      end
   end

   // one-cycle write strobe; register updates at the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_wr    <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
      #1;
   endtask

   // read answer is registered at the taking edge and checked just after it
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_sys_clk);
      i_reg_addr <= a;
      i_reg_rd   <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      #1;
      chk({7'h00, o_reg_rvalid}, 8'h01);
      chk(o_reg_rdata, exp);
   endtask

   // pulse a status register read clear for one port
   task automatic clr(input logic second, input int p);
      @(posedge i_sys_clk);
      if (second) i_status_second_rd <= 4'h1 << p;
      else i_status_first_rd <= 4'h1 << p;
      @(posedge i_sys_clk);
      i_status_first_rd  <= '0;
      i_status_second_rd <= '0;
   endtask

   // one-cycle event pulse, or a level toggle for valid and lock
   task automatic fire(input int e, input int p);
      logic [3:0] m;
      m = 4'h1 << p;
      @(posedge i_sys_clk);
      case (e)
         0: i_encode_error <= m;
         1: i_ctrl_seq_error <= m;
         2: i_ctrl_crc_error <= m;
         3: i_line_length_changed <= m;
         4: i_line_count_changed <= m;
         5: i_rx_overflow <= m;
         6: i_link_parity_error <= m;
         7: i_port_valid <= i_port_valid ^ m;
         default: i_link_lock <= i_link_lock ^ m;
      endcase
      @(posedge i_sys_clk);
      i_encode_error        <= '0;
      i_ctrl_seq_error      <= '0;
      i_ctrl_crc_error      <= '0;
      i_line_length_changed <= '0;
      i_line_count_changed  <= '0;
      i_rx_overflow         <= '0;
      i_link_parity_error   <= '0;
      repeat (3) @(posedge i_sys_clk);
   endtask

   initial begin
      {i_reg_addr, i_reg_rd, i_reg_wr, i_reg_wdata} = '0;
      {i_encode_error, i_ctrl_seq_error, i_ctrl_crc_error} = '0;
      {i_line_length_changed, i_line_count_changed, i_rx_overflow} = '0;
      {i_link_parity_error, i_port_valid, i_link_lock} = '0;
      {i_fwd_line, i_status_first_rd, i_status_second_rd} = '0;
      {err_count, compares, cycles} = '0;
      i_resetn = 1'b0;
      repeat (6) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      // reset values of every port copy, then access kinds on the port 3 copy
      for (int p = 0; p < NUM_PORTS; p++) begin
         wr(ADDR_PORT_SEL, 8'(p));
         rd(ADDR_PORT_SEL, 8'(p));
         rd(ADDR_ISR_HI, 8'h00);
         rd(ADDR_ISR_LO, 8'h00);
         rd(ADDR_LINE_STS, 8'h00);
         rd(ADDR_IE_HI, 8'h00);
      end
      wr(ADDR_ISR_HI, 8'hff);
      rd(ADDR_ISR_HI, 8'h00);
      rd(8'he0, 8'h00);
      wr(ADDR_IE_LO, 8'hff);
      rd(ADDR_IE_LO, 8'h77);
      wr(ADDR_IE_LO, 8'h00);
      // each latched condition on a rotating port, then all on port 0
      // so that the port 0 checks see every kind of event
      for (int n = 0; n < 18; n++) begin
         int e;
         int pt;
         e  = n % 9;
         pt = (n < 9) ? (e % 4) : 0;
         wr(ADDR_PORT_SEL, 8'(pt));
         fire(e, pt);
         rd(ev_addr[e], ev_mask[e]);
         rd(ev_addr[e], ev_mask[e]);
         chk({4'h0, o_port_irq}, 8'h00);
         wr(ev_addr[e] - 8'h02, ev_mask[e]);
         chk({4'h0, o_port_irq}, 8'h01 << pt);
         clr(!ev_sec[e], pt);
         rd(ev_addr[e], ev_mask[e]);
         wr(ADDR_PORT_SEL, 8'((pt + 1) % 4));
         rd(ev_addr[e], 8'h00);
         wr(ADDR_PORT_SEL, 8'(pt));
         clr(ev_sec[e], pt);
         rd(ev_addr[e], 8'h00);
         chk({4'h0, o_port_irq}, 8'h00);
         wr(ev_addr[e] - 8'h02, 8'h00);
      end
      // forward lines of port 1: rise line 0, fall line 3 enabled
      wr(ADDR_PORT_SEL, 8'h01);
      wr(ADDR_EDGE_IE, 8'h81);
      rd(ADDR_EDGE_IE, 8'h00);
      @(posedge i_sys_clk);
      i_fwd_line <= 16'h0090;
      repeat (4) @(posedge i_sys_clk);
      chk({4'h0, o_line_irq}, 8'h02);
      rd(ADDR_LINE_STS, 8'h19);
      rd(ADDR_LINE_STS, 8'h09);
      wr(ADDR_PORT_SEL, 8'h00);
      wr(ADDR_EDGE_IE, 8'h01);
      rd(ADDR_LINE_STS, 8'h00);
      // port 1 lines fall while port 0 line 0 rises
      @(posedge i_sys_clk);
      i_fwd_line <= 16'h0001;
      repeat (4) @(posedge i_sys_clk);
      chk({4'h0, o_line_irq}, 8'h03);
      wr(ADDR_PORT_SEL, 8'h01);
      rd(ADDR_LINE_STS, 8'h80);
      chk({4'h0, o_line_irq}, 8'h01);
      wr(ADDR_PORT_SEL, 8'h00);
      rd(ADDR_LINE_STS, 8'h11);
      chk({4'h0, o_line_irq}, 8'h00);
      summarize();
   end
endmodule
